// file: hw/pcius_map.svh
// Fixed encodings, thresholds and timing counts of the user-side port
`ifndef PCIUS_MAP_SVH
`define PCIUS_MAP_SVH

`define PCIUS_ALMOST_LEFT 4
`define PCIUS_DISCARD_W 15
`define PCIUS_DISCARD_CYCLES 32767
`define PCIUS_HOLD_MIN_CYC 2
`define PCIUS_SKID_DEPTH 2
`define PCIUS_STAT_BITS 3
`define PCIUS_STAT_LAST_IDX 2'h2
`define PCIUS_CMD_IO_READ 4'h2
`define PCIUS_CMD_IO_WRITE 4'h3
`define PCIUS_CMD_MEM_READ 4'h6
`define PCIUS_CMD_MEM_READ_MULT 4'hc
`define PCIUS_CMD_MEM_READ_LINE 4'he

`endif

// file: hw/pcius_pkg.sv
// Shared types of the user-side port
package pcius_pkg;

  typedef logic [3:0] pcius_cmd_t;
  typedef logic [2:0] pcius_bar_t;

  typedef enum logic [1:0] {
    PCIUS_TA_LO = 2'b01,
    PCIUS_TA_HI = 2'b10
  } pcius_ta_state_t;

endpackage : pcius_pkg

// file: hw/pcius_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none

module pcius_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Async reset, low
  input wire logic clr_i, // Synchronous flush
  input wire logic in_valid_i, // Write request
  output logic in_ready_o, // Space available
  input wire logic [WIDTH-1:0] in_data_i, // Write data
  output logic out_valid_o, // Data available
  input wire logic out_ready_i, // Read request
  output logic [WIDTH-1:0] out_data_o, // Head entry
  output logic [$clog2(DEPTH+1)-1:0] count_o // Entries held
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;

  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  wire [AW-1:0] next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [AW-1:0] next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

  // A full FIFO refuses the push, so an over-eager writer loses the word
  assign in_ready_o = (count != CW'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign count_o = count;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (clr_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= next_wr_ptr;
      if (pop) rd_ptr <= next_rd_ptr;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr] <= in_data_i;
  end

  a_fifo_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    count <= CW'(DEPTH)) else $error("fifo count above depth");

endmodule : pcius_fifo

`default_nettype wire

// file: hw/pcius_core.sv
// User-side port of the embedded PCI master/target core
`include "pcius_map.svh"
`timescale 1ns/100ps
`default_nettype none

module pcius_core #(
  parameter int DATA_W = 36,
  parameter int MW_DEPTH = 32,
  parameter int MR_DEPTH = 32,
  parameter int TW_DEPTH = 16,
  parameter int TA_DEPTH = 4,
  parameter int DISCARD_CYCLES = `PCIUS_DISCARD_CYCLES
) (
  input wire logic CLK_I, // 50 MHz clock
  input wire logic RST_N_I, // Async reset, low
  input wire logic PCI_RST_N_I, // PCI bus reset pin, low
  input wire logic MFIFO_CLR_N_I, // Master FIFO clear, low
  input wire logic TFIFO_CLR_N_I, // Target FIFO clear, low
  output logic M_READY_O, // Master side ready
  output logic T_READY_O, // Target side ready
  input wire logic [3:0] MCMD_I, // Master command code
  input wire logic MA_EN_N_I, // Address portion load, low
  input wire logic [31:0] MA_ADDR_I, // Address portion
  output logic MASTER_ADDR_REG_FULL_N_O, // Address register full, low
  input wire logic MA_PCI_TAKE_I, // Core consumed address
  output logic [3:0] MA_CMD_O, // Latched command
  output logic [63:0] MA_ADDR_O, // Latched address
  output logic MA_REUSE_O, // Previous address reused
  input wire logic MW_DATA_EN_N_I, // Master write enable, low
  input wire logic MW_LAST_CYC_N_I, // Master last cycle, low
  input wire logic [DATA_W-1:0] MW_DATA_I, // Master write data
  input wire logic MW_PCI_HOLD_N_I, // Burst hold, low
  output logic MASTER_WRITE_FULL_N_O, // Write FIFO full, low
  output logic MASTER_WRITE_ALMOST_FULL_N_O, // Four left, low
  output logic MASTER_WRITE_EMPTY_N_O, // Write FIFO empty, low
  input wire logic MW_PCI_POP_I, // Core drains one word
  output logic [DATA_W-1:0] MW_PCI_DATA_O, // Word to core
  output logic MW_PCI_LAST_O, // Word is last
  output logic MW_BURST_GO_O, // Burst may start
  input wire logic MR_PCI_PUSH_I, // Core fills one word
  input wire logic [DATA_W-1:0] MR_PCI_DATA_I, // Word from core
  input wire logic MR_PCI_LAST_I, // Word is last
  input wire logic MR_DATA_EN_N_I, // Master read enable, low
  output logic [DATA_W-1:0] MR_DATA_O, // Master read data
  output logic MR_LAST_CYC_N_O, // Final read data, low
  output logic MASTER_READ_EMPTY_N_O, // Read FIFO empty, low
  output logic MASTER_READ_ALMOST_EMPTY_N_O, // Four left, low
  output logic MASTER_READ_FULL_N_O, // Read FIFO full, low
  input wire logic STOP_BURST_N_I, // Stop burst read, low
  output logic MR_STOP_O, // Stop request to core
  input wire logic DT_START_I, // Delayed transaction started
  input wire logic DT_DONE_I, // Delayed transaction done
  output logic DISC_EXP_N_O, // Discard timer expired, low
  input wire logic FPGA_TABORT_I, // Abort request, high
  input wire logic TRETRY_N_I, // Retry request, low
  input wire logic DELTR_N_I, // Delayed request, low
  output logic PCI_TABORT_O, // Abort to core
  output logic PCI_RETRY_O, // Retry to core
  output logic PCI_DELAYED_O, // Delayed to core
  input wire logic TSHIFT_EN_N_I, // Status shift, low
  input wire logic [2:0] TSTAT_I, // Abort, serr, parity
  input wire logic [2:0] TSTAT_MASK_I, // Configuration mask
  output logic TSTAT_O, // Status output
  input wire logic TA_PCI_PUSH_I, // Core queues address
  input wire logic [63:0] TA_PCI_ADDR_I, // Queued address
  input wire logic [3:0] TA_PCI_CMD_I, // Queued command
  input wire logic [2:0] TA_PCI_BAR_I, // Matched BAR
  output logic TA_PCI_READY_O, // Address queue space
  output logic TARGET_REQ_N_O, // Target request, low
  input wire logic TA_EN_N_I, // Address readout, low
  output logic [31:0] TA_DATA_O, // Address portion
  output logic TA_LAST_CYC_N_O, // Final portion, low
  output logic [3:0] TCMD_O, // Target command
  output logic [2:0] BAR_O, // Matched BAR number
  input wire logic TW_PCI_PUSH_I, // Core fills one word
  input wire logic [DATA_W-1:0] TW_PCI_DATA_I, // Word from core
  output logic TW_PCI_READY_O, // Target write space
  input wire logic TW_DATA_EN_N_I, // Target write enable, low
  output logic [DATA_W-1:0] TW_DATA_O, // Target write data
  output logic TW_EMPTY_N_O // Target write empty, low
);

  localparam int MWCW = $clog2(MW_DEPTH + 1);
  localparam int MRCW = $clog2(MR_DEPTH + 1);
  localparam int TWCW = $clog2(TW_DEPTH + 1);
  localparam int SKCW = $clog2(`PCIUS_SKID_DEPTH + 1);
  localparam int TAW = 4 + 3 + 64;

  // Bus reset is a foreign pin
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= PCI_RST_N_I;
      rst_sync <= rst_meta;
    end
  end

  wire m_clr = ~rst_sync | ~MFIFO_CLR_N_I;
  wire t_clr = ~rst_sync | ~TFIFO_CLR_N_I;
  assign M_READY_O = ~m_clr;
  assign T_READY_O = ~t_clr;

  // Master address register
  logic ma_full;
  logic ma_hi_sel;
  logic ma_reuse;
  pcius_pkg::pcius_cmd_t ma_cmd;
  logic [31:0] ma_lo;
  logic [31:0] ma_hi;
  wire ma_last = ~MW_LAST_CYC_N_I;
  wire ma_load = ~MA_EN_N_I & ~ma_full;
  wire ma_reuse_req = ma_last & MA_EN_N_I & MW_DATA_EN_N_I & ~ma_full &
                      ~ma_hi_sel;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ma_full <= 1'b0;
      ma_hi_sel <= 1'b0;
      ma_reuse <= 1'b0;
      ma_cmd <= 4'h0;
      ma_lo <= 32'h0;
      ma_hi <= 32'h0;
    end else if (m_clr) begin
      ma_full <= 1'b0;
      ma_hi_sel <= 1'b0;
    end else if (ma_load) begin
      ma_cmd <= MCMD_I;
      if (ma_hi_sel) ma_hi <= MA_ADDR_I;
      else begin
        ma_lo <= MA_ADDR_I;
        ma_hi <= 32'h0;
      end
      ma_hi_sel <= ~ma_last;
      ma_full <= ma_last;
      ma_reuse <= 1'b0;
    end else if (ma_reuse_req) begin
      ma_cmd <= MCMD_I;
      ma_full <= 1'b1;
      ma_reuse <= 1'b1;
    end else if (MA_PCI_TAKE_I) begin
      ma_full <= 1'b0;
    end
  end
  assign MASTER_ADDR_REG_FULL_N_O = ~ma_full;
  assign MA_CMD_O = ma_cmd;
  assign MA_ADDR_O = {ma_hi, ma_lo};
  assign MA_REUSE_O = ma_reuse;

  // Master write FIFO; last flag rides as the top bit
  logic mw_in_ready;
  logic mw_out_valid;
  logic [DATA_W:0] mw_head;
  logic [MWCW-1:0] mw_count;
  pcius_fifo #(.WIDTH(DATA_W + 1), .DEPTH(MW_DEPTH)) u_mw_fifo (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .clr_i(m_clr),
    .in_valid_i(~MW_DATA_EN_N_I),
    .in_ready_o(mw_in_ready),
    .in_data_i({~MW_LAST_CYC_N_I, MW_DATA_I}),
    .out_valid_o(mw_out_valid),
    .out_ready_i(MW_PCI_POP_I),
    .out_data_o(mw_head),
    .count_o(mw_count)
  );
  wire [MWCW-1:0] mw_free = MWCW'(MW_DEPTH) - mw_count;
  assign MASTER_WRITE_FULL_N_O = mw_in_ready;
  assign MASTER_WRITE_ALMOST_FULL_N_O =
    (mw_free > MWCW'(`PCIUS_ALMOST_LEFT));
  assign MASTER_WRITE_EMPTY_N_O = mw_out_valid;
  assign MW_PCI_DATA_O = mw_head[DATA_W-1:0];
  assign MW_PCI_LAST_O = mw_head[DATA_W];
  // Hold only waits for fill; a full FIFO starts the burst anyway
  assign MW_BURST_GO_O = mw_out_valid & (MW_PCI_HOLD_N_I | ~mw_in_ready);

  // Master read FIFO, then a two-entry skid buffer to the user
  logic mr_out_valid;
  logic sk_in_ready;
  logic sk_out_valid;
  logic [DATA_W:0] mr_head;
  logic [DATA_W:0] sk_head;
  logic [MRCW-1:0] mr_count;
  logic [SKCW-1:0] sk_count;
  pcius_fifo #(.WIDTH(DATA_W + 1), .DEPTH(MR_DEPTH)) u_mr_fifo (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .clr_i(m_clr),
    .in_valid_i(MR_PCI_PUSH_I),
    .in_ready_o(MASTER_READ_FULL_N_O),
    .in_data_i({MR_PCI_LAST_I, MR_PCI_DATA_I}),
    .out_valid_o(mr_out_valid),
    .out_ready_i(sk_in_ready),
    .out_data_o(mr_head),
    .count_o(mr_count)
  );
  pcius_fifo #(.WIDTH(DATA_W + 1), .DEPTH(`PCIUS_SKID_DEPTH)) u_mr_skid (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .clr_i(m_clr),
    .in_valid_i(mr_out_valid),
    .in_ready_o(sk_in_ready),
    .in_data_i(mr_head),
    .out_valid_o(sk_out_valid),
    .out_ready_i(~MR_DATA_EN_N_I),
    .out_data_o(sk_head),
    .count_o(sk_count)
  );
  wire [MRCW:0] mr_total = (MRCW + 1)'(mr_count) + (MRCW + 1)'(sk_count);
  assign MR_DATA_O = sk_head[DATA_W-1:0];
  assign MR_LAST_CYC_N_O = ~(sk_out_valid & sk_head[DATA_W]);
  assign MASTER_READ_EMPTY_N_O = sk_out_valid;
  assign MASTER_READ_ALMOST_EMPTY_N_O =
    (mr_total > (MRCW + 1)'(`PCIUS_ALMOST_LEFT));

  // Discard timer; retried transaction after expiry counts as new
  logic [`PCIUS_DISCARD_W-1:0] disc_cnt;
  logic disc_run;
  logic disc_exp;
  wire disc_end = (disc_cnt == `PCIUS_DISCARD_W'(DISCARD_CYCLES - 1));
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      disc_cnt <= '0;
      disc_run <= 1'b0;
      disc_exp <= 1'b0;
    end else if (DT_START_I) begin
      disc_cnt <= '0;
      disc_run <= 1'b1;
      disc_exp <= 1'b0;
    end else if (DT_DONE_I) begin
      disc_run <= 1'b0;
      // Expiry wins a tie with completion
      disc_exp <= disc_run & disc_end;
    end else if (disc_run) begin
      disc_cnt <= disc_cnt + 1'b1;
      if (disc_end) begin
        disc_run <= 1'b0;
        disc_exp <= 1'b1;
      end
    end
  end
  assign DISC_EXP_N_O = ~disc_exp;

  // Target address queue: {command, BAR, address}
  logic ta_valid;
  logic [TAW-1:0] ta_head;
  pcius_pkg::pcius_ta_state_t ta_state;
  pcius_pkg::pcius_ta_state_t next_ta_state;
  wire ta_needs_hi = |ta_head[63:32];
  wire ta_rd = ~TA_EN_N_I & ta_valid;
  wire ta_last = (ta_state == pcius_pkg::PCIUS_TA_HI) | ~ta_needs_hi;
  wire ta_pop = ta_rd & ta_last;
  pcius_fifo #(.WIDTH(TAW), .DEPTH(TA_DEPTH)) u_ta_fifo (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .clr_i(t_clr),
    .in_valid_i(TA_PCI_PUSH_I),
    .in_ready_o(TA_PCI_READY_O),
    .in_data_i({TA_PCI_CMD_I, TA_PCI_BAR_I, TA_PCI_ADDR_I}),
    .out_valid_o(ta_valid),
    .out_ready_i(ta_pop),
    .out_data_o(ta_head),
    .count_o()
  );
  always_comb begin
    next_ta_state = ta_state;
    unique case (ta_state)
      pcius_pkg::PCIUS_TA_LO: begin
        if (ta_rd && !ta_last) next_ta_state = pcius_pkg::PCIUS_TA_HI;
      end
      pcius_pkg::PCIUS_TA_HI: begin
        if (ta_rd) next_ta_state = pcius_pkg::PCIUS_TA_LO;
      end
      default: next_ta_state = pcius_pkg::PCIUS_TA_LO;
    endcase
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) ta_state <= pcius_pkg::PCIUS_TA_LO;
    else if (t_clr) ta_state <= pcius_pkg::PCIUS_TA_LO;
    else ta_state <= next_ta_state;
  end
  assign TARGET_REQ_N_O = ~ta_valid;
  assign TA_DATA_O = (ta_state == pcius_pkg::PCIUS_TA_HI) ?
                     ta_head[63:32] : ta_head[31:0];
  assign TA_LAST_CYC_N_O = ~(ta_valid & ta_last);
  // Valid only while the request is low
  assign TCMD_O = ta_head[TAW-1 -: 4];
  assign BAR_O = ta_head[66:64];

  // Target write FIFO
  logic [TWCW-1:0] tw_count;
  pcius_fifo #(.WIDTH(DATA_W), .DEPTH(TW_DEPTH)) u_tw_fifo (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .clr_i(t_clr),
    .in_valid_i(TW_PCI_PUSH_I),
    .in_ready_o(TW_PCI_READY_O),
    .in_data_i(TW_PCI_DATA_I),
    .out_valid_o(TW_EMPTY_N_O),
    .out_ready_i(~TW_DATA_EN_N_I),
    .out_data_o(TW_DATA_O),
    .count_o(tw_count)
  );

  // Memory writes are posted, so only I/O writes, I/O reads and memory reads may be delayed
  pcius_pkg::pcius_cmd_t t_cmd;
  assign t_cmd = ta_head[TAW-1 -: 4];
  wire dt_cmd_ok = (t_cmd == `PCIUS_CMD_IO_WRITE) |
                   (t_cmd == `PCIUS_CMD_IO_READ) |
                   (t_cmd == `PCIUS_CMD_MEM_READ) |
                   (t_cmd == `PCIUS_CMD_MEM_READ_MULT) |
                   (t_cmd == `PCIUS_CMD_MEM_READ_LINE);

  // Status output: masked OR, or one unmasked bit per clock
  logic [1:0] stat_idx;
  logic stat_out;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      MR_STOP_O <= 1'b0;
      PCI_TABORT_O <= 1'b0;
      PCI_RETRY_O <= 1'b0;
      PCI_DELAYED_O <= 1'b0;
      stat_idx <= 2'h0;
      stat_out <= 1'b0;
    end else begin
      MR_STOP_O <= ~STOP_BURST_N_I;
      PCI_TABORT_O <= FPGA_TABORT_I;
      PCI_RETRY_O <= ~TRETRY_N_I;
      PCI_DELAYED_O <= ~DELTR_N_I & ta_valid & dt_cmd_ok;
      if (TSHIFT_EN_N_I) begin
        stat_idx <= 2'h0;
        stat_out <= |(TSTAT_I & TSTAT_MASK_I);
      end else begin
        stat_out <= TSTAT_I[stat_idx];
        stat_idx <= (stat_idx == `PCIUS_STAT_LAST_IDX) ? 2'h0 :
                    stat_idx + 1'b1;
      end
    end
  end
  assign TSTAT_O = stat_out;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_bus_reset_ready: assert property ($fell(PCI_RST_N_I) |-> ##2
    (!M_READY_O && !T_READY_O)) else $error("ready high in bus reset");
  a_mw_store_word: assert property ((!MW_DATA_EN_N_I &&
    MASTER_WRITE_FULL_N_O && !MW_PCI_POP_I && !m_clr) |=>
    (mw_count == $past(mw_count) + 1'b1)) else $error("write not stored");
  a_mw_afull_flag: assert property ((mw_count >= MWCW'(MW_DEPTH - 4)) ==
    !MASTER_WRITE_ALMOST_FULL_N_O) else $error("almost full wrong");
  a_mr_aempty_flag: assert property ((mr_total <= 4) ==
    !MASTER_READ_ALMOST_EMPTY_N_O) else $error("almost empty wrong");
  a_mr_last_data: assert property (!MR_LAST_CYC_N_O |->
    MASTER_READ_EMPTY_N_O) else $error("last without data");
  a_disc_expiry: assert property ($rose(disc_exp) |->
    ($past(disc_cnt) == `PCIUS_DISCARD_W'(DISCARD_CYCLES - 1)))
    else $error("discard expiry early or late");
  a_abort_forward: assert property (FPGA_TABORT_I ##1 FPGA_TABORT_I |->
    PCI_TABORT_O) else $error("abort not forwarded");
  a_retry_forward: assert property (!TRETRY_N_I |=> PCI_RETRY_O)
    else $error("retry not forwarded");
  a_delay_cmd_ok: assert property (PCI_DELAYED_O |->
    $past(dt_cmd_ok)) else $error("delayed on posted write");
  a_stat_first_bit: assert property ($rose(!TSHIFT_EN_N_I) |=>
    (TSTAT_O == $past(TSTAT_I[0]))) else $error("shift not from bit 0");
  a_tclr_empties: assert property (!TFIFO_CLR_N_I |=>
    (TARGET_REQ_N_O && !TW_EMPTY_N_O)) else $error("target clear failed");
  a_treq_on_push: assert property ((TA_PCI_PUSH_I && TA_PCI_READY_O &&
    !t_clr) |=> !TARGET_REQ_N_O) else $error("request not raised");
  a_ta_second_word: assert property ((ta_rd && !ta_last && !t_clr) |=>
    (!TA_LAST_CYC_N_O && !TARGET_REQ_N_O)) else $error("high word lost");
  a_tw_read_word: assert property ((!TW_DATA_EN_N_I && TW_EMPTY_N_O &&
    !TW_PCI_PUSH_I && !t_clr) |=> (tw_count == $past(tw_count) - 1'b1))
    else $error("target write not read");

  c_burst_on_full: cover property (!MW_PCI_HOLD_N_I && MW_BURST_GO_O);
  c_addr_reuse: cover property (ma_reuse_req);
  c_two_word_addr: cover property (ta_rd && !ta_last ##1 ta_pop);
  c_read_stall: cover property (MR_DATA_EN_N_I && !sk_in_ready);

endmodule : pcius_core

`default_nettype wire

// file: dv/pcius_user_model.sv
// Behavioural user logic driving the held request pins
`timescale 1ns/100ps
`default_nettype none

module pcius_user_model (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Async reset, low
  input wire logic addr_free_i, // Address register not full
  output logic [3:0] cmd_o, // Master command
  output logic [4:0] req_o // Hold, stop, abort, retry, delayed
);
  int cnt [5];

  // Changes on the falling edge, seen by the core on the rising one
  always @(negedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_o <= 5'h00;
      cmd_o <= 4'h0;
    end else begin
      cmd_o <= 4'($urandom_range(15));
      for (int b = 0; b < 5; b++) begin
        // Stop must outlive the address register as well
        if (req_o[b] && (cnt[b] < 2 || (b == 1 && !addr_free_i))) begin
          cnt[b] <= cnt[b] + 1;
        end else begin
          req_o[b] <= ($urandom_range(7) == 0);
          cnt[b] <= 1;
        end
      end
    end
  end
endmodule : pcius_user_model

`default_nettype wire

// file: dv/pcius_core_test.sv
// Self-checking bench of the user-side port
`timescale 1ns/100ps
`default_nettype none

module pcius_core_test;
  // Starts low by declaration so that no false edge appears at time zero
  logic CLK_I = 1'b0;
  logic RST_N_I, PCI_RST_N_I, MFIFO_CLR_N_I, TFIFO_CLR_N_I;
  logic MA_EN_N_I, MA_PCI_TAKE_I, MW_DATA_EN_N_I, MW_LAST_CYC_N_I;
  logic MW_PCI_HOLD_N_I, MW_PCI_POP_I, MR_PCI_PUSH_I, MR_PCI_LAST_I;
  logic MR_DATA_EN_N_I, STOP_BURST_N_I, DT_START_I, DT_DONE_I;
  logic FPGA_TABORT_I, TRETRY_N_I, DELTR_N_I, TSHIFT_EN_N_I, TA_PCI_PUSH_I;
  logic TA_EN_N_I, TW_PCI_PUSH_I, TW_DATA_EN_N_I;
  logic [3:0] MCMD_I, TA_PCI_CMD_I, MA_CMD_O, TCMD_O;
  logic [31:0] MA_ADDR_I, TA_DATA_O;
  logic [63:0] TA_PCI_ADDR_I, MA_ADDR_O;
  logic [35:0] MW_DATA_I, MR_PCI_DATA_I, TW_PCI_DATA_I;
  logic [35:0] MW_PCI_DATA_O, MR_DATA_O, TW_DATA_O;
  logic [2:0] TSTAT_I, TSTAT_MASK_I, TA_PCI_BAR_I, BAR_O;
  logic M_READY_O, T_READY_O, MASTER_ADDR_REG_FULL_N_O, MA_REUSE_O;
  logic MASTER_WRITE_FULL_N_O, MASTER_WRITE_ALMOST_FULL_N_O;
  logic MASTER_WRITE_EMPTY_N_O, MW_PCI_LAST_O, MW_BURST_GO_O;
  logic MR_LAST_CYC_N_O, MASTER_READ_EMPTY_N_O, MASTER_READ_ALMOST_EMPTY_N_O;
  logic MASTER_READ_FULL_N_O, MR_STOP_O, DISC_EXP_N_O, PCI_TABORT_O;
  logic PCI_RETRY_O, PCI_DELAYED_O, TSTAT_O, TA_PCI_READY_O, TARGET_REQ_N_O;
  logic TA_LAST_CYC_N_O, TW_PCI_READY_O, TW_EMPTY_N_O, chk_on;
  logic [4:0] ur;
  logic [3:0] prev;
  logic [3:0] pcmd;
  logic [35:0] q [32];
  logic [67:0] a [2];
  int num_errors = 0;
  int tests_run = 0;
  int n;
  wire [3:0] rq = {PCI_TABORT_O, PCI_RETRY_O, MR_STOP_O, PCI_DELAYED_O};

  // Short discard count keeps the expiry test brief
  pcius_core #(.DISCARD_CYCLES(8)) i_pcius_core (.*);
  pcius_user_model i_pcius_user_model (.clk_i(CLK_I), .rst_n_i(RST_N_I),
    .addr_free_i(MASTER_ADDR_REG_FULL_N_O), .cmd_o(MCMD_I), .req_o(ur));
  assign {DELTR_N_I, TRETRY_N_I, FPGA_TABORT_I} = {~ur[4], ~ur[3], ur[2]};
  assign {STOP_BURST_N_I, MW_PCI_HOLD_N_I} = ~ur[1:0];

  task automatic chk(input logic c, input string m);
    tests_run++;
    if (c !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge CLK_I);
  endtask : cyc

  // Memory writes are posted, so only I/O writes, I/O reads and memory reads may be delayed
  function automatic logic dly_ok(input logic [3:0] c);
    return c inside {4'h2, 4'h3, 4'h6, 4'hc, 4'he};
  endfunction : dly_ok

  task automatic tally_and_finish();
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    forever #10 CLK_I = ~CLK_I;
  end

  initial begin
    #100us;
    num_errors++;
    $display("CHECK FAILED at %0t: timeout", $time);
    tally_and_finish();
  end

  // Registered requests follow their pins one clock late
  always @(posedge CLK_I) begin
    prev <= {FPGA_TABORT_I, ~TRETRY_N_I, ~STOP_BURST_N_I,
             ~DELTR_N_I & !TARGET_REQ_N_O & dly_ok(TCMD_O)};
    pcmd <= MCMD_I;
  end
  always @(negedge CLK_I) begin
    if (chk_on) chk(rq === prev, "req");
  end

  initial begin
    {RST_N_I, chk_on, MA_PCI_TAKE_I, DT_DONE_I, MW_PCI_POP_I} = 5'h00;
    {MR_PCI_PUSH_I, DT_START_I, TA_PCI_PUSH_I, TW_PCI_PUSH_I} = 4'h0;
    {PCI_RST_N_I, MFIFO_CLR_N_I, TFIFO_CLR_N_I, MA_EN_N_I} = 4'hf;
    {MW_DATA_EN_N_I, MW_LAST_CYC_N_I, MR_DATA_EN_N_I} = 3'h7;
    {TSHIFT_EN_N_I, TA_EN_N_I, TW_DATA_EN_N_I, MR_PCI_LAST_I} = 4'he;
    {MA_ADDR_I, MW_DATA_I, MR_PCI_DATA_I, TW_PCI_DATA_I} = '0;
    {TSTAT_I, TSTAT_MASK_I, TA_PCI_ADDR_I, TA_PCI_CMD_I, TA_PCI_BAR_I} = '0;
    void'($urandom(57));
    cyc(1);
    chk(!M_READY_O && !T_READY_O, "ready in reset");
    cyc(1);
    RST_N_I = 1'b1;
    cyc(4);
    chk(M_READY_O && T_READY_O, "ready");
    chk_on = 1'b1;
    PCI_RST_N_I = 1'b0;
    cyc(3);
    chk(!M_READY_O && !T_READY_O, "bus reset");
    PCI_RST_N_I = 1'b1;
    cyc(4);
    MFIFO_CLR_N_I = 1'b0;
    cyc(1);
    chk(!M_READY_O && T_READY_O, "master clear");
    {MFIFO_CLR_N_I, TFIFO_CLR_N_I} = 2'b10;
    cyc(1);
    chk(M_READY_O && !T_READY_O, "target clear");
    TFIFO_CLR_N_I = 1'b1;
    // Two address portions, then a reuse request after the core takes it
    a[0] = 68'({$urandom, $urandom});
    for (int k = 0; k < 2; k++) begin
      MA_ADDR_I = a[0][32*k +: 32];
      {MA_EN_N_I, MW_LAST_CYC_N_I} = {1'b0, k == 0};
      cyc(1);
    end
    {MA_EN_N_I, MW_LAST_CYC_N_I, MA_PCI_TAKE_I} = 3'b111;
    chk(!MASTER_ADDR_REG_FULL_N_O && MA_ADDR_O === a[0], "ma");
    chk(!MA_REUSE_O && MA_CMD_O === pcmd, "ma cmd");
    cyc(1);
    {MA_PCI_TAKE_I, MW_LAST_CYC_N_I} = 2'b00;
    chk(MASTER_ADDR_REG_FULL_N_O, "ma taken");
    cyc(1);
    {MA_PCI_TAKE_I, MW_LAST_CYC_N_I} = 2'b11;
    chk(!MASTER_ADDR_REG_FULL_N_O && MA_REUSE_O, "reuse");
    chk(MA_ADDR_O === a[0] && MA_CMD_O === pcmd, "reuse cmd");
    cyc(1);
    MA_PCI_TAKE_I = 1'b0;
    // One write past full must be dropped
    for (int i = 0; i < 33; i++) begin
      MW_DATA_I = 36'({$urandom, $urandom});
      if (i < 32) q[i] = MW_DATA_I;
      {MW_DATA_EN_N_I, MW_LAST_CYC_N_I} = {1'b0, i != 31};
      cyc(1);
      n = (i < 32) ? i + 1 : 32;
      chk(MASTER_WRITE_EMPTY_N_O && MASTER_WRITE_FULL_N_O === (n < 32), "mw");
      chk(MASTER_WRITE_ALMOST_FULL_N_O === (32 - n > 4), "mw almost");
      chk(MW_BURST_GO_O === (MW_PCI_HOLD_N_I || n == 32), "burst");
    end
    {MW_DATA_EN_N_I, MW_LAST_CYC_N_I, MW_PCI_POP_I} = 3'h7;
    for (int i = 0; i < 32; i++) begin
      chk(MW_PCI_DATA_O === q[i] && MW_PCI_LAST_O === (i == 31), "mw data");
      cyc(1);
    end
    MW_PCI_POP_I = 1'b0;
    chk(!MASTER_WRITE_EMPTY_N_O && !MW_BURST_GO_O, "mw empty");
    for (int i = 0; i < 6; i++) begin
      MR_PCI_DATA_I = 36'({$urandom, $urandom});
      q[i] = MR_PCI_DATA_I;
      {MR_PCI_PUSH_I, MR_PCI_LAST_I} = {1'b1, i == 5};
      cyc(1);
    end
    MR_PCI_PUSH_I = 1'b0;
    cyc(3);
    chk(MASTER_READ_EMPTY_N_O && MASTER_READ_FULL_N_O, "mr flags");
    for (int i = 0; i < 6; i++) begin
      chk(MR_DATA_O === q[i] && MR_LAST_CYC_N_O === (i != 5), "mr data");
      chk(MASTER_READ_ALMOST_EMPTY_N_O === (6 - i > 4), "mr almost");
      MR_DATA_EN_N_I = 1'b0;
      cyc(1);
    end
    MR_DATA_EN_N_I = 1'b1;
    chk(!MASTER_READ_EMPTY_N_O && MR_LAST_CYC_N_O, "mr empty");
    for (int k = 0; k < 2; k++) begin
      a[k] = {4'($urandom), k ? 32'h0 : (32'($urandom) | 32'h1),
              32'($urandom)};
      {TA_PCI_CMD_I, TA_PCI_ADDR_I} = a[k];
      TA_PCI_BAR_I = 3'(2 * k + 2);
      TW_PCI_DATA_I = 36'({$urandom, $urandom});
      q[k] = TW_PCI_DATA_I;
      {TA_PCI_PUSH_I, TW_PCI_PUSH_I} = 2'b11;
      cyc(1);
    end
    {TA_PCI_PUSH_I, TW_PCI_PUSH_I} = 2'b00;
    chk(!TARGET_REQ_N_O && TA_DATA_O === a[0][31:0] && BAR_O === 3'h2, "ta");
    chk(TA_LAST_CYC_N_O && TCMD_O === 4'(a[0] >> 64), "ta cmd");
    TA_EN_N_I = 1'b0;
    cyc(1);
    chk(TA_DATA_O === a[0][63:32] && !TA_LAST_CYC_N_O, "ta high");
    cyc(1);
    chk(!TARGET_REQ_N_O && TA_DATA_O === a[1][31:0] && !TA_LAST_CYC_N_O, "ta 2");
    chk(BAR_O === 3'h4 && TCMD_O === TA_PCI_CMD_I, "ta bar");
    cyc(1);
    TA_EN_N_I = 1'b1;
    chk(TARGET_REQ_N_O, "ta idle");
    for (int i = 0; i < 2; i++) begin
      chk(TW_EMPTY_N_O && TW_DATA_O === q[i], "tw data");
      TW_DATA_EN_N_I = 1'b0;
      cyc(1);
    end
    TW_DATA_EN_N_I = 1'b1;
    chk(!TW_EMPTY_N_O, "tw empty");
    {TW_PCI_PUSH_I, TA_PCI_PUSH_I} = 2'b11;
    cyc(2);
    {TW_PCI_PUSH_I, TA_PCI_PUSH_I, TFIFO_CLR_N_I} = 3'b000;
    cyc(1);
    TFIFO_CLR_N_I = 1'b1;
    cyc(1);
    chk(!TW_EMPTY_N_O && TARGET_REQ_N_O, "target clear");
    for (int r = 0; r < 4; r++) begin
      {TSTAT_I, TSTAT_MASK_I} = 6'($urandom);
      cyc(2);
      chk(TSTAT_O === |(TSTAT_I & TSTAT_MASK_I), "status or");
      TSHIFT_EN_N_I = 1'b0;
      for (int i = 0; i < 4; i++) begin
        cyc(1);
        chk(TSTAT_O === TSTAT_I[i % 3], "status shift");
      end
      TSHIFT_EN_N_I = 1'b1;
    end
    DT_START_I = 1'b1;
    cyc(1);
    DT_START_I = 1'b0;
    cyc(1);
    chk(DISC_EXP_N_O, "discard early");
    n = 0;
    while (DISC_EXP_N_O !== 1'b0 && n < 20) begin
      cyc(1);
      n++;
    end
    chk(n == 7, "discard time");
    DT_START_I = 1'b1;
    cyc(1);
    {DT_START_I, DT_DONE_I} = 2'b01;
    chk(DISC_EXP_N_O, "discard restart");
    cyc(1);
    DT_DONE_I = 1'b0;
    cyc(10);
    chk(DISC_EXP_N_O, "discard stopped");
    tally_and_finish();
  end
endmodule : pcius_core_test

`default_nettype wire
